// *** rtl/card_decode_pkg.sv ***
package card_decode_pkg;
  // Attribute space
  localparam logic [14:0] ATTR_OPTION_ADDR = 15'h0800;
  localparam logic [14:0] ATTR_STATUS_ADDR = 15'h0802;
  localparam int          ATTR_CFG_BIT     = 11;
  localparam logic [7:0]  CARD_OPTION_RST  = 8'h00;
  localparam logic [7:0]  CARD_STATUS_RST  = 8'h00;
  localparam logic [7:0]  UNDEF_DATA       = 8'hff;
  // Flash page holding attribute image and reset code
  localparam logic [1:0]  TOP_FLASH_PAGE   = 2'h3;
  localparam logic [4:0]  ATTR_FLASH_HI    = 5'h1f;
  // I/O offsets within the six decoded bits
  localparam logic [5:0]  IO_GEN_CFG   = 6'h00;
  localparam logic [5:0]  IO_BANK_SEL  = 6'h01;
  localparam logic [5:0]  IO_PTR_LO    = 6'h02;
  localparam logic [5:0]  IO_PTR_HI    = 6'h03;
  localparam logic [5:0]  IO_DATA_LO   = 6'h04;
  localparam logic [5:0]  IO_DATA_HI   = 6'h07;
  localparam logic [5:0]  IO_XCVR_BASE = 6'h08;
  localparam logic [5:0]  IO_NARROW_END = 6'h10;
  localparam logic [5:0]  IO_WIDE_END   = 6'h28;
  // Bank select fields
  localparam int          BANK_EXPAND_BIT = 2;
  localparam int          BANK_DEV_BIT    = 5;
  localparam logic [7:0]  BANK_SEL_RST    = 8'h00;
  localparam logic [7:0]  GEN_CFG_RST     = 8'h00;
  // Core address map
  localparam logic [15:0] CORE_XCVR_BASE  = 16'h0400;
  localparam logic [15:0] CORE_SIDE_BASE  = 16'h0420;
  localparam logic [15:0] CORE_SIDE_END   = 16'h0440;
  localparam logic [16:0] CORE_RESET_ADDR = 17'h1fff0;

  // Host-side cycle strobes and address
  typedef struct packed {
    logic        reg_sel;
    logic        ce1;
    logic        oe;
    logic        we;
    logic        iord;
    logic        iowr;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } host_cycle_t;

  // Request to external memory
  typedef struct packed {
    logic        sram_sel;
    logic        flash_sel;
    logic        wr;
    logic [16:0] addr;
    logic [7:0]  wdata;
  } mem_req_t;
endpackage

// *** rtl/pc_card_memory_io_decoder.sv ***
`timescale 1ns/100ps
// Summary of operation
// - Even attribute addresses below 2K read flash top
// - Option and status registers at 0800h, 0802h
// - Odd addresses above them read undefined
// - Any A11 attribute read is answered
// - Only the two config registers are writable in attribute space
// - Expand bit sets 16 or 40 byte window
// - I/O decodes only six low address bits
// - Bank bit 5 picks SRAM or flash
// - Memory address is bank bits plus pointer
// - Every data port access bumps the pointer
// - Core 0400h-041Fh hits transceiver registers
// - Core 0420h-043Fh hits core-side registers
// - Core fetches first from top flash bytes
// - I/O exposes config, bank, transceiver registers
// - All memory reachable through pointer ports
// - Bank field pages SRAM then flash
module pc_card_memory_io_decoder #(
  parameter int PTR_W = 15
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire card_decode_pkg::host_cycle_t host,
  output logic [7:0]                     host_rdata,
  output logic                           host_ack,
  output card_decode_pkg::mem_req_t      mem_req,
  input  wire logic [7:0]                mem_rdata,
  output logic                           xcvr_sel,
  output logic                           xcvr_wr,
  output logic [4:0]                     xcvr_addr,
  output logic [7:0]                     xcvr_wdata,
  input  wire logic [7:0]                xcvr_rdata,
  input  wire logic                      core_sel,
  input  wire logic [15:0]               core_addr,
  output logic                           core_to_xcvr,
  output logic                           core_to_side,
  output logic                           core_to_sram,
  output logic [16:0]                    core_boot_addr,
  output logic [7:0]                     card_option,
  output logic [7:0]                     card_config_status,
  output logic [7:0]                     general_config,
  output logic [7:0]                     bank_select
);

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD} cyc_state_t;

  cyc_state_t         state_reg;
  logic [7:0]         card_option_reg;
  logic [7:0]         card_config_status_reg;
  logic [7:0]         general_config_reg;
  logic [7:0]         bank_select_reg;
  logic [PTR_W-1:0]   local_mem_pointer;
  logic [7:0]         rdata_reg;
  logic               ack_reg;

  // Decode terms
  logic        attr_rd;
  logic        attr_wr;
  logic        io_rd;
  logic        io_wr;
  logic        io_cyc;
  logic [5:0]  io_off;
  logic        io_claim;
  logic        io_data;
  logic        io_xcvr;
  logic        new_cyc;
  logic        cyc_open;
  logic [4:0]  xcvr_idx;

  // Window end depends on the expand bit
  function automatic logic [5:0] window_end(input logic [7:0] bank);
    if (bank[card_decode_pkg::BANK_EXPAND_BIT])
      window_end = card_decode_pkg::IO_WIDE_END;
    else
      window_end = card_decode_pkg::IO_NARROW_END;
  endfunction

  assign attr_rd = host.reg_sel && host.ce1 && host.oe;
  assign attr_wr = host.reg_sel && host.ce1 && host.we;
  assign io_rd   = host.ce1 && host.iord;
  assign io_wr   = host.ce1 && host.iowr;
  assign io_cyc  = io_rd || io_wr;
  assign io_off  = host.addr[5:0];
  assign io_claim = io_off < window_end(bank_select_reg);
  assign io_data = io_claim && io_off >= card_decode_pkg::IO_DATA_LO &&
                   io_off <= card_decode_pkg::IO_DATA_HI;
  assign io_xcvr = io_claim && io_off >= card_decode_pkg::IO_XCVR_BASE;
  // Only the first edge of a held strobe starts an access
  assign cyc_open = (state_reg == ST_IDLE);
  assign new_cyc  = cyc_open && (attr_rd || attr_wr || io_cyc);

  // Transceiver index: narrow window pages by bank bits 1:0
  always_comb begin
    logic [5:0] rel;
    rel = io_off - card_decode_pkg::IO_XCVR_BASE;
    if (bank_select_reg[card_decode_pkg::BANK_EXPAND_BIT])
      xcvr_idx = rel[4:0];
    else
      xcvr_idx = {bank_select_reg[1:0], rel[2:0]};
  end

  // One action per strobe; wait for strobes to drop
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (new_cyc)
            state_reg <= ST_HOLD;
        end
        ST_HOLD: begin
          if (!(attr_rd || attr_wr || io_cyc))
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Card configuration registers, the only writable attribute bytes
  always_ff @(posedge clk) begin
    if (rst) begin
      card_option_reg        <= card_decode_pkg::CARD_OPTION_RST;
      card_config_status_reg <= card_decode_pkg::CARD_STATUS_RST;
    end else if (new_cyc && attr_wr) begin
      if (host.addr == card_decode_pkg::ATTR_OPTION_ADDR)
        card_option_reg <= host.wdata;
      if (host.addr == card_decode_pkg::ATTR_STATUS_ADDR)
        card_config_status_reg <= host.wdata;
    end
  end

  // General config and bank select in the I/O window
  always_ff @(posedge clk) begin
    if (rst) begin
      general_config_reg <= card_decode_pkg::GEN_CFG_RST;
      bank_select_reg    <= card_decode_pkg::BANK_SEL_RST;
    end else if (new_cyc && io_wr) begin
      if (io_off == card_decode_pkg::IO_GEN_CFG)
        general_config_reg <= host.wdata;
      if (io_off == card_decode_pkg::IO_BANK_SEL)
        bank_select_reg <= host.wdata;
    end
  end

  // Pointer: written in two halves, bumped after each data access
  always_ff @(posedge clk) begin
    if (rst)
      local_mem_pointer <= '0;
    else if (new_cyc && io_cyc) begin
      if (io_data)
        local_mem_pointer <= local_mem_pointer + 1'b1;
      else if (io_wr && io_off == card_decode_pkg::IO_PTR_LO)
        local_mem_pointer[7:0] <= host.wdata;
      else if (io_wr && io_off == card_decode_pkg::IO_PTR_HI)
        local_mem_pointer[PTR_W-1:8] <= host.wdata[PTR_W-9:0];
    end
  end

  // Memory request routing; only the taking cycle reaches memory, so a
  // strobe held across the pointer bump cannot write a second byte
  always_comb begin
    mem_req = '0;
    if (cyc_open && attr_rd && !host.addr[card_decode_pkg::ATTR_CFG_BIT] &&
        !host.addr[0]) begin
      mem_req.flash_sel = 1'b1;
      mem_req.addr = {card_decode_pkg::ATTR_FLASH_HI,
                      card_decode_pkg::TOP_FLASH_PAGE, host.addr[10:1]};
    end else if (cyc_open && io_cyc && io_data) begin
      mem_req.flash_sel = bank_select_reg[card_decode_pkg::BANK_DEV_BIT];
      mem_req.sram_sel  = !bank_select_reg[card_decode_pkg::BANK_DEV_BIT];
      mem_req.addr  = {bank_select_reg[4:3], local_mem_pointer};
      mem_req.wr    = io_wr;
      mem_req.wdata = host.wdata;
    end
  end

  // Transceiver register port
  always_comb begin
    xcvr_sel   = cyc_open && io_cyc && io_xcvr;
    xcvr_wr    = cyc_open && io_wr && io_xcvr;
    xcvr_addr  = xcvr_idx;
    xcvr_wdata = host.wdata;
  end

  // Read data capture, registered
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= '0;
      ack_reg   <= 1'b0;
    end else begin
      ack_reg <= new_cyc && (attr_rd || (io_cyc && io_claim) ||
                 attr_wr);
      if (new_cyc && attr_rd) begin
        if (!host.addr[card_decode_pkg::ATTR_CFG_BIT])
          rdata_reg <= host.addr[0] ? card_decode_pkg::UNDEF_DATA
                                    : mem_rdata;
        else if (host.addr == card_decode_pkg::ATTR_OPTION_ADDR)
          rdata_reg <= card_option_reg;
        else if (host.addr == card_decode_pkg::ATTR_STATUS_ADDR)
          rdata_reg <= card_config_status_reg;
        else
          rdata_reg <= card_decode_pkg::UNDEF_DATA;
      end else if (new_cyc && io_rd) begin
        if (io_data)
          rdata_reg <= mem_rdata;
        else if (io_xcvr)
          rdata_reg <= xcvr_rdata;
        else if (io_off == card_decode_pkg::IO_GEN_CFG)
          rdata_reg <= general_config_reg;
        else if (io_off == card_decode_pkg::IO_BANK_SEL)
          rdata_reg <= bank_select_reg;
        else if (io_off == card_decode_pkg::IO_PTR_LO)
          rdata_reg <= local_mem_pointer[7:0];
        else if (io_off == card_decode_pkg::IO_PTR_HI)
          rdata_reg <= 8'(local_mem_pointer[PTR_W-1:8]);
        else
          rdata_reg <= card_decode_pkg::UNDEF_DATA;
      end
    end
  end

  // Core-side address steering
  always_comb begin
    core_to_xcvr = core_sel && core_addr >= card_decode_pkg::CORE_XCVR_BASE
                   && core_addr < card_decode_pkg::CORE_SIDE_BASE;
    core_to_side = core_sel && core_addr >= card_decode_pkg::CORE_SIDE_BASE
                   && core_addr < card_decode_pkg::CORE_SIDE_END;
    core_to_sram = core_sel && !core_to_xcvr && !core_to_side;
  end

  assign core_boot_addr     = card_decode_pkg::CORE_RESET_ADDR;
  assign host_rdata         = rdata_reg;
  assign host_ack           = ack_reg;
  assign card_option        = card_option_reg;
  assign card_config_status = card_config_status_reg;
  assign general_config     = general_config_reg;
  assign bank_select        = bank_select_reg;

  chk_ptr_bump: assert property (@(posedge clk) disable iff (rst)
    new_cyc && io_cyc && io_data |=>
      local_mem_pointer == $past(local_mem_pointer) + 1'b1)
    else $error("pointer did not advance");
  chk_io_window: assert property (@(posedge clk) disable iff (rst)
    !bank_select_reg[2] && io_cyc && io_off >= 6'h10 |-> !xcvr_sel)
    else $error("narrow window claimed high offset");
  chk_attr_ro: assert property (@(posedge clk) disable iff (rst)
    attr_wr |-> !mem_req.wr)
    else $error("attribute write reached memory");
  chk_dev_sel: assert property (@(posedge clk) disable iff (rst)
    new_cyc && io_cyc && io_data |-> mem_req.flash_sel == bank_select_reg[5]
      && mem_req.sram_sel != mem_req.flash_sel)
    else $error("wrong memory device");
  chk_mem_addr: assert property (@(posedge clk) disable iff (rst)
    new_cyc && io_cyc && io_data |->
      mem_req.addr[16:15] == bank_select_reg[4:3])
    else $error("bank bits missing from address");
  chk_attr_flash: assert property (@(posedge clk) disable iff (rst)
    new_cyc && attr_rd && !host.addr[11] && !host.addr[0] |->
      mem_req.flash_sel && mem_req.addr[16:10] == 7'h7f)
    else $error("attribute read missed flash top");
  chk_option_wr: assert property (@(posedge clk) disable iff (rst)
    new_cyc && attr_wr && host.addr == 15'h0800 |=>
      card_option_reg == $past(host.wdata))
    else $error("option register not written");
  chk_core_xcvr: assert property (@(posedge clk) disable iff (rst)
    core_sel && core_addr[15:5] == 11'h020 |-> core_to_xcvr && !core_to_sram)
    else $error("core access not steered");

  // Held strobes stay quiet and every answer is a single pulse
  chk_hold_quiet: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_HOLD |-> !mem_req.wr && !xcvr_wr)
    else $error("held strobe repeated a write");
  chk_ack_pulse: assert property (@(posedge clk) disable iff (rst)
    host_ack |=> !host_ack)
    else $error("acknowledge longer than one cycle");
  chk_odd_undef: assert property (@(posedge clk) disable iff (rst)
    new_cyc && attr_rd && host.addr[14:2] == 13'h0200 && host.addr[0] |=>
      host_rdata == card_decode_pkg::UNDEF_DATA)
    else $error("odd register neighbour not undefined");
  chk_a11_ack: assert property (@(posedge clk) disable iff (rst)
    new_cyc && attr_rd && host.addr[11] |=> host_ack)
    else $error("upper attribute read not answered");
  chk_cfg_ro: assert property (@(posedge clk) disable iff (rst)
    new_cyc && attr_wr && !host.addr[11] |=>
      card_option_reg == $past(card_option_reg) &&
      card_config_status_reg == $past(card_config_status_reg))
    else $error("flash range write changed a register");
  chk_wide_claim: assert property (@(posedge clk) disable iff (rst)
    new_cyc && io_cyc && bank_select_reg[2] && io_off < 6'h28 |=> host_ack)
    else $error("wide window offset not claimed");
  chk_io_alias: assert property (@(posedge clk) disable iff (rst)
    new_cyc && io_wr && host.addr[5:0] == 6'h01 |=>
      bank_select_reg == $past(host.wdata))
    else $error("aliased bank select write lost");
  chk_core_side: assert property (@(posedge clk) disable iff (rst)
    core_sel && core_addr[15:5] == 11'h021 |-> core_to_side && !core_to_sram)
    else $error("core side access not steered");
endmodule

// *** tb/mem_partner.sv ***
`timescale 1ns/100ps
// Behavioural SRAM, flash and transceiver bank on the far side
module mem_partner (
  input  wire logic                      clk,
  input  wire card_decode_pkg::mem_req_t mem_req,
  output logic [7:0]                     mem_rdata,
  input  wire logic                      xcvr_sel,
  input  wire logic                      xcvr_wr,
  input  wire logic [4:0]                xcvr_addr,
  input  wire logic [7:0]                xcvr_wdata,
  output logic [7:0]                     xcvr_rdata
);
  logic [7:0] sram [131072];
  logic [7:0] xregs [32];
  logic [7:0] last_reg = 8'h00;

  // Preset contents with address-derived bytes
  initial begin
    for (int i = 0; i < 131072; i++) sram[i] = 8'(i) ^ 8'h33;
    for (int i = 0; i < 32; i++) xregs[i] = 8'(i) ^ 8'h80;
  end

  // Released lines show the inverse of the last byte, never a stale copy
  always_comb begin
    if (mem_req.flash_sel) mem_rdata = mem_req.addr[7:0] ^ mem_req.addr[15:8];
    else if (mem_req.sram_sel) mem_rdata = sram[mem_req.addr];
    else mem_rdata = ~last_reg;
    xcvr_rdata = xcvr_sel ? xregs[xcvr_addr] : ~last_reg;
  end

  // Store writes; flash ignores them
  always @(posedge clk) begin
    if (mem_req.sram_sel && mem_req.wr) sram[mem_req.addr] <= mem_req.wdata;
    if (xcvr_sel && xcvr_wr) xregs[xcvr_addr] <= xcvr_wdata;
    last_reg <= mem_rdata;
  end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/100ps
// Host bench for attribute, I/O and core decode paths
module testbench;
  typedef struct { int k; logic [14:0] a; logic [7:0] d, e; } row_t;
  logic                         clk = 1'b0;
  logic                         rst = 1'b1;
  card_decode_pkg::host_cycle_t host = '0;
  card_decode_pkg::mem_req_t    mem_req, req;
  logic [7:0]  host_rdata, mem_rdata, xcvr_wdata, xcvr_rdata, rd;
  logic [7:0]  card_option, card_config_status, general_config, bank_select;
  logic        host_ack, xcvr_sel, xcvr_wr, ok;
  logic        core_to_xcvr, core_to_side, core_to_sram;
  logic        core_sel = 1'b0;
  logic [15:0] core_addr = '0;
  logic [4:0]  xcvr_addr, xa;
  logic [16:0] core_boot_addr, ea;
  int          num_errors = 0;
  int          total_checks = 0;

  always #4 clk = ~clk;

  pc_card_memory_io_decoder i_pc_card_memory_io_decoder (.clk, .rst, .host,
    .host_rdata, .host_ack, .mem_req, .mem_rdata, .xcvr_sel, .xcvr_wr,
    .xcvr_addr, .xcvr_wdata, .xcvr_rdata, .core_sel, .core_addr,
    .core_to_xcvr, .core_to_side, .core_to_sram, .core_boot_addr,
    .card_option, .card_config_status, .general_config, .bank_select);

  mem_partner i_mem_partner (.clk, .mem_req, .mem_rdata, .xcvr_sel,
    .xcvr_wr, .xcvr_addr, .xcvr_wdata, .xcvr_rdata);

  function automatic logic [7:0] pat(input logic fl, input logic [16:0] a);
    return fl ? a[7:0] ^ a[15:8] : a[7:0] ^ 8'h33;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One host access: k 0 attr read, 1 attr write, 2 io read, 3 io write
  task automatic cyc(input int k, input logic [14:0] a,
                     input logic [7:0] d = 8'h00, input int hold = 0);
    @(negedge clk);
    host = '{reg_sel: k < 2, ce1: 1'b1, oe: k == 0, we: k == 1,
             iord: k == 2, iowr: k == 3, addr: a, wdata: d};
    #1;
    req = mem_req;
    xa = xcvr_addr;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      #1;
      ok = (host_ack === 1'b1);
      rd = host_rdata;
    end
    repeat (hold + 1) @(posedge clk); // Hold the strobe hold+1 more edges after the ack edge
    @(negedge clk);
    host = '0;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    row_t        rows [13];
    logic [31:0] win [5];
    logic [19:0] cores [6];
    rows = '{'{0, 15'h0000, 8'h00, 8'hfc}, '{0, 15'h07fe, 8'h00, 8'h00},
             '{0, 15'h0122, 8'h00, 8'h6d}, '{0, 15'h0011, 8'h00, 8'hff},
             '{1, 15'h0800, 8'ha5, 8'h00}, '{1, 15'h0802, 8'h3c, 8'h00},
             '{1, 15'h0010, 8'h77, 8'h00}, '{0, 15'h0800, 8'h00, 8'ha5},
             '{0, 15'h0802, 8'h00, 8'h3c}, '{0, 15'h0801, 8'h00, 8'hff},
             '{0, 15'h0803, 8'h00, 8'hff}, '{0, 15'h4a00, 8'h00, 8'hff},
             '{0, 15'h0010, 8'h00, 8'hf4}};
    win = '{32'h000f0107, 32'h00100000, 32'h03090119, 32'h0427011f,
            32'h04280000};
    cores = '{20'h103ff, 20'h40400, 20'h4041f, 20'h20420, 20'h2043f,
              20'h10440};
    repeat (12) @(negedge clk);
    rst = 1'b0;
    check({card_option, card_config_status}, 0);
    check({general_config, bank_select}, 0);
    for (int i = 0; i < 13; i++) begin
      cyc(rows[i].k, rows[i].a, rows[i].d);
      check(ok, 1'b1);
      if (rows[i].k == 0) check(rd, rows[i].e);
      if (rows[i].k == 0 && rows[i].a < 15'h0800 && !rows[i].a[0])
        check(req.addr, 17'h1fc00 + 17'(rows[i].a[10:1]));
      if (rows[i].k == 1)
        check(req.wr & (req.sram_sel | req.flash_sel), 0);
    end
    check({card_option, card_config_status}, 16'ha53c);
    // Register aliasing in I/O space
    cyc(3, 15'h0000, 8'h5a);
    cyc(2, 15'h0040);
    check({rd, general_config}, 16'h5a5a);
    cyc(3, 15'h0001, 8'h07);
    cyc(2, 15'h7fc1);
    check({rd, bank_select}, 16'h0707);
    // Window edges and transceiver indexing
    for (int i = 0; i < 5; i++) begin
      cyc(3, 15'h0001, win[i][31:24]);
      cyc(2, 15'(win[i][23:16]));
      check(ok, win[i][8]);
      if (ok) check({xa, rd}, {win[i][4:0], 8'h80 ^ win[i][7:0]});
    end
    cyc(3, 15'h000a, 8'hc3);
    cyc(2, 15'h000a);
    check({xa, rd}, {5'h02, 8'hc3});
    // Pointer kept clear of vector and reserved SRAM
    cyc(3, 15'h0001, 8'h00);
    cyc(3, 15'h0002, 8'h00);
    cyc(3, 15'h0003, 8'h05);
    cyc(2, 15'h0003);
    check(rd, 8'h05);
    cyc(3, 15'h0004, 8'h11);
    check({req.sram_sel, req.flash_sel, req.wr, req.addr, req.wdata},
          {3'b101, 17'h00500, 8'h11});
    cyc(3, 15'h7fc5, 8'h22);
    check({req.addr, req.wdata}, {17'h00501, 8'h22});
    cyc(3, 15'h0002, 8'h00);
    cyc(2, 15'h0006, 8'h00, 3);
    check(rd, 8'h11);
    cyc(2, 15'h0007);
    check({req.addr, rd}, {17'h00501, 8'h22});
    // Every bank code through the data port
    cyc(3, 15'h0002, 8'hf0);
    cyc(3, 15'h0003, 8'hff);
    for (int b = 0; b < 8; b++) begin
      cyc(3, 15'h0001, 8'(b << 3));
      cyc(2, 15'h0004);
      ea = {b[1:0], 15'h7ff0 + 15'(b)};
      check({req.flash_sel, req.sram_sel}, {b[2], !b[2]});
      check({req.addr, rd}, {ea, pat(b[2], ea)});
    end
    // Core-side address steering
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      core_sel = 1'b1;
      core_addr = cores[i][15:0];
      #1;
      check({core_to_xcvr, core_to_side, core_to_sram},
            cores[i][18:16]);
    end
    check(core_boot_addr, 17'h1fff0);
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    check({card_option, bank_select}, 16'h0000);
    check({card_config_status, general_config}, 16'h0000);
    cyc(0, 15'h0800);
    check({ok, rd}, {1'b1, 8'h00});
    results();
  end

  // Cut a hung run short
  initial begin
    #100000;
    num_errors++;
    results();
  end
endmodule
